// ### logic/phy_interrupt_logic.sv
`timescale 1ns/1ns
// Overview of operation
// - autoneg event interrupts only when its mask set
// - speed event interrupts only when its mask set
// - duplex event interrupts only when its mask set
// - link event interrupts only when its mask set
// - global enable gates all event interrupts
// - force test bit asserts interrupt regardless
// - autoneg flag reports completion, read clears it
// - speed flag sets on change, read clears
// - duplex flag sets on change, read clears
// - link flag sets on change, read clears
// - pending bit mirrors the interrupt output
// - speed source is the 100 Mb/s indication
// - autoneg complete counts only while enabled
module phy_interrupt_logic #(
  parameter int ADDR_W = 5
) (
  // clock, reset and clock enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // management register port
  input wire phy_irq_pkg::mgmt_req_t mgmtReq,
  output phy_irq_pkg::mgmt_rsp_t mgmtRsp,
  // event source levels from the rest of the transceiver
  input wire logic speedIs100,
  input wire logic duplexFull,
  input wire logic linkUp,
  input wire logic autonegEnabled,
  input wire logic autonegComplete,
  // management interrupt pin, active low
  output logic mgmtIrqN
);

  // the request carries a fixed five-bit address
  if (ADDR_W != phy_irq_pkg::REG_ADDR_W) begin : g_bad_addr
    $error("phy_interrupt_logic: ADDR_W must be 5");
  end

  // ---- reset release synchroniser ----

  logic rstMeta_reg; // first stage, read only by the second
  logic rstSync_reg; // synchronised active-low reset for the design
  logic rstMeta_next;
  logic rstSync_next;

  // next values of the synchroniser
  always_comb begin
    rstMeta_next = 1'b1;
    rstSync_next = rstMeta_reg;
  end

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= rstMeta_next;
      rstSync_reg <= rstSync_next;
    end
  end

  // ---- request decode ----

  logic statusRead; // read of the event status register
  logic maskWrite; // write of the mask control register

  // decode address and strobes
  always_comb begin
    statusRead = mgmtReq.rd &&
                 (mgmtReq.addr == phy_irq_pkg::EVENT_STATUS_ADDR);
    maskWrite = mgmtReq.wr &&
                (mgmtReq.addr == phy_irq_pkg::MASK_CTRL_ADDR);
  end

  // ---- event sources ----

  phy_irq_pkg::event_vec_t evPulse; // one-cycle event pulses
  logic speedChange; // speed indication toggled
  logic duplexChange; // duplex indication toggled
  logic linkChange; // link indication toggled
  logic anRise; // autoneg completion reached
  logic anQualified; // completion only counts while autoneg enabled

  // qualify the completion indication
  always_comb begin
    anQualified = autonegEnabled & autonegComplete;
  end

  // speed source is the 100 Mb/s indication
  change_detect #(.WIDTH(1), .RISE_ONLY(1'b0)) u_speed_det (
    .clk(clk),
    .resetN(rstSync_reg),
    .clkEn(clkEn),
    .level(speedIs100),
    .changed(speedChange)
  );

  // duplex mode change
  change_detect #(.WIDTH(1), .RISE_ONLY(1'b0)) u_duplex_det (
    .clk(clk),
    .resetN(rstSync_reg),
    .clkEn(clkEn),
    .level(duplexFull),
    .changed(duplexChange)
  );

  // link status change
  change_detect #(.WIDTH(1), .RISE_ONLY(1'b0)) u_link_det (
    .clk(clk),
    .resetN(rstSync_reg),
    .clkEn(clkEn),
    .level(linkUp),
    .changed(linkChange)
  );

  // completion of auto-negotiation, rising edge only
  change_detect #(.WIDTH(1), .RISE_ONLY(1'b1)) u_an_det (
    .clk(clk),
    .resetN(rstSync_reg),
    .clkEn(clkEn),
    .level(anQualified),
    .changed(anRise)
  );

  // gather pulses into the event vector
  always_comb begin
    evPulse.autoneg = anRise;
    evPulse.speed = speedChange;
    evPulse.duplex = duplexChange;
    evPulse.link = linkChange;
  end

  // ---- mask control register ----

  logic [15:0] maskCtrl_reg; // stored mask, enable and force bits
  logic [15:0] maskCtrl_next;

  // write only the defined bits, reserved bits hold zero
  always_comb begin
    maskCtrl_next = maskCtrl_reg;
    if (maskWrite) begin
      // host keeps reserved bits zero; we drop them anyway
      maskCtrl_next = mgmtReq.wdata & phy_irq_pkg::MASK_CTRL_WRITABLE;
    end
  end

  // mask control register storage
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      maskCtrl_reg <= phy_irq_pkg::MASK_CTRL_RESET;
    end else if (clkEn) begin
      maskCtrl_reg <= maskCtrl_next;
    end
  end

  // ---- sticky event flags ----

  phy_irq_pkg::event_vec_t flags_reg; // latched event flags
  phy_irq_pkg::event_vec_t flags_next;

  // set by an event, cleared by a status read; set wins over clear
  always_comb begin
    flags_next.autoneg = (flags_reg.autoneg & ~statusRead) |
                         evPulse.autoneg;
    flags_next.speed = (flags_reg.speed & ~statusRead) |
                       evPulse.speed;
    flags_next.duplex = (flags_reg.duplex & ~statusRead) |
                        evPulse.duplex;
    flags_next.link = (flags_reg.link & ~statusRead) |
                      evPulse.link;
  end

  // flag storage
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      flags_reg <= phy_irq_pkg::EVENT_FLAGS_RESET;
    end else if (clkEn) begin
      flags_reg <= flags_next;
    end
  end

  // ---- interrupt generation ----

  phy_irq_pkg::event_vec_t maskVec; // per-event mask bits
  logic globalEn; // master interrupt switch
  logic forceIrq; // test bit forcing the pin
  logic anyMasked; // some flag set with its mask set
  logic irq_reg; // interrupt pending state
  logic irq_next;
  logic mgmtIrqN_reg; // pin driver, active low
  logic mgmtIrqN_next;

  // combine the updated flags with the updated mask register
  always_comb begin
    maskVec.autoneg = maskCtrl_next[phy_irq_pkg::AN_DONE_MASK_BIT];
    maskVec.speed = maskCtrl_next[phy_irq_pkg::SPEED_CHANGE_MASK_BIT];
    maskVec.duplex = maskCtrl_next[phy_irq_pkg::DUPLEX_CHANGE_MASK_BIT];
    maskVec.link = maskCtrl_next[phy_irq_pkg::LINK_CHANGE_MASK_BIT];
    globalEn = maskCtrl_next[phy_irq_pkg::IRQ_GLOBAL_ENABLE_BIT];
    forceIrq = maskCtrl_next[phy_irq_pkg::IRQ_FORCE_TEST_BIT];
    anyMasked = (flags_next.autoneg & maskVec.autoneg) |
                (flags_next.speed & maskVec.speed) |
                (flags_next.duplex & maskVec.duplex) |
                (flags_next.link & maskVec.link);
    // drops once a read has cleared every masked flag and the force bit is clear
    irq_next = forceIrq | (globalEn & anyMasked);
    mgmtIrqN_next = ~irq_next;
  end

  // interrupt state and pin
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      irq_reg <= 1'b0;
      mgmtIrqN_reg <= 1'b1;
    end else if (clkEn) begin
      irq_reg <= irq_next;
      mgmtIrqN_reg <= mgmtIrqN_next;
    end
  end

  // ---- read answer ----

  phy_irq_pkg::mgmt_rsp_t rsp_reg; // registered read answer
  phy_irq_pkg::mgmt_rsp_t rsp_next;
  logic [15:0] statusWord; // assembled status register value

  // status word shows flags before the read clears them
  always_comb begin
    statusWord = 16'h0000;
    statusWord[phy_irq_pkg::AUTONEG_DONE_FLAG_BIT] = flags_reg.autoneg;
    statusWord[phy_irq_pkg::SPEED_CHANGED_FLAG_BIT] = flags_reg.speed;
    statusWord[phy_irq_pkg::DUPLEX_CHANGED_FLAG_BIT] = flags_reg.duplex;
    statusWord[phy_irq_pkg::LINK_CHANGED_FLAG_BIT] = flags_reg.link;
    statusWord[phy_irq_pkg::MGMT_IRQ_PENDING_BIT] = irq_reg;
  end

  // select the read data, unmapped addresses read zero
  always_comb begin
    rsp_next.valid = mgmtReq.rd;
    rsp_next.rdata = rsp_reg.rdata;
    if (mgmtReq.rd) begin
      case (mgmtReq.addr)
        // mask register, reserved bits read zero
        phy_irq_pkg::MASK_CTRL_ADDR: begin
          rsp_next.rdata = maskCtrl_reg;
        end
        // status register
        phy_irq_pkg::EVENT_STATUS_ADDR: begin
          rsp_next.rdata = statusWord;
        end
        // anything else
        default: begin
          rsp_next.rdata = phy_irq_pkg::READ_DATA_RESET;
        end
      endcase
    end
  end

  // answer storage
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      rsp_reg.valid <= 1'b0;
      rsp_reg.rdata <= phy_irq_pkg::READ_DATA_RESET;
    end else if (clkEn) begin
      rsp_reg <= rsp_next;
    end
  end

  // ---- outputs straight from flip-flops ----
  assign mgmtRsp = rsp_reg;
  assign mgmtIrqN = mgmtIrqN_reg;

endmodule

// ### include/phy_irq_pkg.sv
// shared constants and carrier types for the transceiver interrupt logic
package phy_irq_pkg;

  // management register address and data widths
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 16;

  // register addresses on the management register port
  localparam logic [4:0] MASK_CTRL_ADDR = 5'h12;
  localparam logic [4:0] EVENT_STATUS_ADDR = 5'h13;

  // field positions in interrupt_mask_control
  localparam int AN_DONE_MASK_BIT = 7;
  localparam int SPEED_CHANGE_MASK_BIT = 6;
  localparam int DUPLEX_CHANGE_MASK_BIT = 5;
  localparam int LINK_CHANGE_MASK_BIT = 4;
  localparam int IRQ_GLOBAL_ENABLE_BIT = 1;
  localparam int IRQ_FORCE_TEST_BIT = 0;

  // field positions in interrupt_event_status
  localparam int AUTONEG_DONE_FLAG_BIT = 7;
  localparam int SPEED_CHANGED_FLAG_BIT = 6;
  localparam int DUPLEX_CHANGED_FLAG_BIT = 5;
  localparam int LINK_CHANGED_FLAG_BIT = 4;
  localparam int MGMT_IRQ_PENDING_BIT = 2;

  // bits of interrupt_mask_control that hold storage; the rest read zero
  localparam logic [15:0] MASK_CTRL_WRITABLE = 16'h00f3;

  // values after reset
  localparam logic [15:0] MASK_CTRL_RESET = 16'h0000;
  localparam logic [15:0] READ_DATA_RESET = 16'h0000;
  localparam logic [3:0] EVENT_FLAGS_RESET = 4'h0;

  // stages of the reset release synchroniser
  localparam int RESET_SYNC_STAGES = 2;

  // one bit per event source, in status bit order 7..4
  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
    logic link;
  } event_vec_t;

  // management register access, one request per cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  // registered answer to a read
  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } mgmt_rsp_t;

endpackage

// ### logic/change_detect.sv
`timescale 1ns/1ns
// flags a change (or only a rise) of a level input, one pulse per change
module change_detect #(
  parameter int WIDTH = 1,
  parameter bit RISE_ONLY = 1'b0
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetN,
  input wire logic clkEn,
  // watched level and change pulse
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] changed
);

  // refuse widths the logic cannot serve
  if (WIDTH < 1) begin : g_bad_width
    $error("change_detect: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] prev_reg; // level seen at the last enabled edge
  logic [WIDTH-1:0] prev_next;
  logic primed_reg; // low until the first sample after reset
  logic primed_next;

  // next values and the change pulse
  always_comb begin
    prev_next = level;
    primed_next = 1'b1;
    // no event on the first sample, the level at reset is no change
    if (!primed_reg) begin
      changed = '0;
    end else if (RISE_ONLY) begin
      changed = level & ~prev_reg;
    end else begin
      changed = level ^ prev_reg;
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
    end else if (clkEn) begin
      prev_reg <= prev_next;
      primed_reg <= primed_next;
    end
  end

endmodule

// ### test/phy_irq_props.sv
`timescale 1ns/1ns
// watches the interrupt pin and the register answers at the top ports
module phy_irq_props (
  // clock, reset and enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // register port
  input wire phy_irq_pkg::mgmt_req_t mgmtReq,
  input wire phy_irq_pkg::mgmt_rsp_t mgmtRsp,
  // event levels
  input wire logic speedIs100,
  input wire logic duplexFull,
  input wire logic linkUp,
  input wire logic autonegEnabled,
  input wire logic autonegComplete,
  // interrupt pin
  input wire logic mgmtIrqN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] maskCopy_reg; // copy of the mask register built from writes
  logic [15:0] maskCopy_next; // next copy
  logic wrMask; // mask write taken this edge
  logic [4:0] lvls; // all event levels together
  assign wrMask = clkEn && mgmtReq.wr &&
    mgmtReq.addr == phy_irq_pkg::MASK_CTRL_ADDR;
  assign lvls = {speedIs100, duplexFull, linkUp, autonegEnabled,
    autonegComplete};
  // next mask copy follows taken writes
  always_comb begin
    maskCopy_next = wrMask ? mgmtReq.wdata : maskCopy_reg;
  end
  // registers the mask copy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      maskCopy_reg <= 16'h0000;
    end else begin
      maskCopy_reg <= maskCopy_next;
    end
  end
  sequence statusRd;
    clkEn && mgmtReq.rd && mgmtReq.addr == phy_irq_pkg::EVENT_STATUS_ADDR;
  endsequence
  sequence quiet;
    clkEn && !mgmtReq.rd && !mgmtReq.wr && $stable(lvls);
  endsequence
  force_irq_a: assert property (
    wrMask && mgmtReq.wdata[0] |=> !mgmtIrqN)
    else $error("force write left the pin high");
  global_off_a: assert property (
    wrMask && mgmtReq.wdata[1:0] == 2'b00 |=> mgmtIrqN)
    else $error("pin low with global enable off");
  mask_off_a: assert property (
    wrMask && mgmtReq.wdata[7:4] == 4'h0 && !mgmtReq.wdata[0] |=> mgmtIrqN)
    else $error("pin low with all masks off");
  pending_bit_a: assert property (statusRd |=>
    mgmtRsp.valid && mgmtRsp.rdata[2] == !$past(mgmtIrqN))
    else $error("pending bit differs from the pin");
  mask_reserved_a: assert property (
    clkEn && mgmtReq.rd && mgmtReq.addr == phy_irq_pkg::MASK_CTRL_ADDR
    |=> mgmtRsp.rdata[15:8] == 8'h00 && mgmtRsp.rdata[3:2] == 2'b00)
    else $error("reserved mask bits not zero");
  read_clears_a: assert property (
    statusRd ##0 ($stable(lvls) && $past(clkEn)) ##1 quiet ##1 statusRd
    |=> mgmtRsp.rdata[7:4] == 4'h0)
    else $error("flags survived a status read");
  // an edge with the enable low before it leaves the change pending
  event_irq_a: assert property (
    clkEn && $past(clkEn) && !mgmtReq.wr && maskCopy_reg[1] &&
    (($changed(speedIs100) && maskCopy_reg[6]) ||
     ($changed(duplexFull) && maskCopy_reg[5]) ||
     ($changed(linkUp) && maskCopy_reg[4])) |=> !mgmtIrqN)
    else $error("masked event gave no interrupt");
  irq_hold_a: assert property (
    !mgmtIrqN ##0 quiet |=> !mgmtIrqN)
    else $error("interrupt dropped without a read");
  // completion while enabled, with its mask and the master switch on
  an_irq_a: assert property (
    clkEn && $past(clkEn) && !mgmtReq.wr && maskCopy_reg[1] &&
    maskCopy_reg[7] && $rose(autonegEnabled && autonegComplete)
    |=> !mgmtIrqN)
    else $error("autoneg event gave no interrupt");
  // a low enable holds the pin and the read answer
  freeze_hold_a: assert property (
    !clkEn |=> $stable(mgmtIrqN) && $stable(mgmtRsp))
    else $error("state moved while the enable was low");
endmodule

bind phy_interrupt_logic phy_irq_props u_phy_irq_props (.clk(clk),
  .reset_n(reset_n), .clkEn(clkEn), .mgmtReq(mgmtReq), .mgmtRsp(mgmtRsp),
  .speedIs100(speedIs100), .duplexFull(duplexFull), .linkUp(linkUp),
  .autonegEnabled(autonegEnabled), .autonegComplete(autonegComplete),
  .mgmtIrqN(mgmtIrqN));

// ### test/mgmt_host.sv
`timescale 1ns/1ns
// station management host issuing register reads and writes
module mgmt_host (
  // clock
  input wire logic clk,
  // register port toward the device
  output phy_irq_pkg::mgmt_req_t mgmtReq,
  input wire phy_irq_pkg::mgmt_rsp_t mgmtRsp
);
  initial mgmtReq = '0;
  // one write; reserved bits always sent as zero
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmtReq.wr <= 1'b1;
    mgmtReq.addr <= a;
    mgmtReq.wdata <= d & phy_irq_pkg::MASK_CTRL_WRITABLE;
    @(posedge clk);
    mgmtReq.wr <= 1'b0;
    mgmtReq.wdata <= ~d; // released data shows junk
    #1;
  endtask
  // one read; answer taken one cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d,
      output logic v);
    @(posedge clk);
    mgmtReq.rd <= 1'b1;
    mgmtReq.addr <= a;
    @(posedge clk);
    mgmtReq.rd <= 1'b0;
    mgmtReq.addr <= ~a; // released address shows junk
    #1;
    v = mgmtRsp.valid;
    d = mgmtRsp.rdata;
  endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the transceiver interrupt logic
module tb_top;
  logic clk, reset_n, clkEn; // clock, reset, enable
  logic speedIs100, duplexFull, linkUp, autonegEnabled, autonegComplete;
  phy_irq_pkg::mgmt_req_t mgmtReq; // host requests
  phy_irq_pkg::mgmt_rsp_t mgmtRsp; // device answers
  logic mgmtIrqN; // interrupt pin
  logic [15:0] rdData; // last read word
  logic rdValid; // last read answer flag
  int err_count, cmp_count, cycleCount;
  localparam logic [4:0] MA = phy_irq_pkg::MASK_CTRL_ADDR;
  localparam logic [4:0] SA = phy_irq_pkg::EVENT_STATUS_ADDR;
  phy_interrupt_logic u_phy_interrupt_logic (.clk(clk), .reset_n(reset_n),
    .clkEn(clkEn), .mgmtReq(mgmtReq), .mgmtRsp(mgmtRsp),
    .speedIs100(speedIs100), .duplexFull(duplexFull), .linkUp(linkUp),
    .autonegEnabled(autonegEnabled), .autonegComplete(autonegComplete),
    .mgmtIrqN(mgmtIrqN));
  mgmt_host u_mgmt_host (.clk(clk), .mgmtReq(mgmtReq), .mgmtRsp(mgmtRsp));
  always #50 clk = ~clk;
  // cuts a hang short
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 5000) begin
      err_count++;
      end_sim();
    end
  end
  // compares one value
  task check(input string name, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reads a register and checks the answer
  task rd_chk(input logic [4:0] a, input logic [15:0] exp);
    u_mgmt_host.rd_reg(a, rdData, rdValid);
    check("answer valid", {15'h0000, rdValid}, 16'h0001);
    check("read data", rdData, exp);
  endtask
  task irq_chk(input logic e);
    check("irq pin", {15'h0000, mgmtIrqN}, {15'h0000, e});
  endtask
  // raises event i: 0 autoneg, 1 speed, 2 duplex, 3 link
  task fire(input int i);
    @(posedge clk);
    case (i)
      0: begin
        autonegComplete <= 1'b0;
        @(posedge clk);
        autonegComplete <= 1'b1;
      end
      1: speedIs100 <= ~speedIs100;
      2: duplexFull <= ~duplexFull;
      default: linkUp <= ~linkUp;
    endcase
    @(posedge clk);
    #1;
  endtask
  task t_reset;
    rd_chk(MA, 16'h0000);
    rd_chk(SA, 16'h0000);
    irq_chk(1'b1);
  endtask
  task t_force;
    u_mgmt_host.wr_reg(MA, 16'h0001);
    irq_chk(1'b0);
    rd_chk(SA, 16'h0004);
    u_mgmt_host.wr_reg(MA, 16'h0000);
    irq_chk(1'b1);
  endtask
  task t_events;
    logic [15:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 16'h0080 >> i;
      u_mgmt_host.wr_reg(MA, 16'h0002);
      fire(i);
      irq_chk(1'b1);
      rd_chk(SA, b);
      u_mgmt_host.wr_reg(MA, b | 16'h0002);
      fire(i);
      irq_chk(1'b0);
      rd_chk(SA, b | 16'h0004);
      irq_chk(1'b1);
      rd_chk(SA, 16'h0000);
    end
  endtask
  task t_global;
    u_mgmt_host.wr_reg(MA, 16'h00f0);
    fire(3);
    irq_chk(1'b1);
    u_mgmt_host.wr_reg(MA, 16'h00f2);
    irq_chk(1'b0);
    rd_chk(SA, 16'h0014);
    u_mgmt_host.wr_reg(MA, 16'h0000);
  endtask
  // enable low freezes state; a link change waits until it returns
  task t_freeze;
    u_mgmt_host.wr_reg(MA, 16'h0012);
    @(posedge clk);
    clkEn <= 1'b0;
    linkUp <= ~linkUp;
    repeat (3) @(posedge clk);
    #1;
    irq_chk(1'b1);
    @(posedge clk);
    clkEn <= 1'b1;
    @(posedge clk);
    #1;
    irq_chk(1'b0);
    rd_chk(SA, 16'h0014);
    u_mgmt_host.wr_reg(MA, 16'h0000);
  endtask
  task t_an_off;
    @(posedge clk);
    autonegEnabled <= 1'b0;
    fire(0);
    rd_chk(SA, 16'h0000);
  endtask
  task t_refuse;
    u_mgmt_host.wr_reg(SA, 16'h00f4);
    rd_chk(SA, 16'h0000);
    rd_chk(5'h14, 16'h0000);
    u_mgmt_host.wr_reg(MA, 16'hffff);
    rd_chk(MA, 16'h00f3);
    irq_chk(1'b0);
    u_mgmt_host.wr_reg(MA, 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    {speedIs100, duplexFull, linkUp, autonegComplete} = 4'h0;
    autonegEnabled = 1'b1;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_force();
    t_events();
    t_global();
    t_freeze();
    t_an_off();
    t_refuse();
    end_sim();
  end
endmodule
